// [hdl/tofcr_pkg.sv]
// Package: register map, field layout, reset values and carriers of the channel register slice
package tofcr_pkg;
  // Register offsets, as seen on the serial port
  localparam logic [5:0] ADDR_CONFIG_ONE = 6'h00;
  localparam logic [5:0] ADDR_CONFIG_TWO = 6'h01;
  localparam logic [5:0] ADDR_STATUS = 6'h02;
  localparam logic [5:0] ADDR_MASK = 6'h03;
  localparam logic [5:0] ADDR_COARSE_HI = 6'h04;
  // Reset values
  localparam logic [7:0] RST_CONFIG_TWO = 8'h40;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h07;
  localparam logic [7:0] RST_COARSE_HI = 8'hff;
  // Implemented bits; the rest are reserved and read zero
  localparam logic [7:0] STATUS_USED = 8'h1f;
  localparam logic [7:0] MASK_USED = 8'h07;
  // Field positions
  localparam int BEGIN_BIT = 0;
  localparam int ST_DONE = 4;
  localparam int ST_STARTED = 3;
  localparam int ST_REF_OVF = 2;
  localparam int ST_COARSE_OVF = 1;
  localparam int ST_RESULT = 0;
  localparam int CMD_WRITE_BIT = 6;
  // Serial frame: command byte then data byte
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD = 2'b01,
    SPI_DATA = 2'b11,
    SPI_TAIL = 2'b10
  } tofcr_spi_e;

  // Event strobes from the measurement engine
  typedef struct packed {
    logic done;
    logic started;
    logic ref_ovf;
    logic coarse_ovf;
  } tofcr_events_s;

  // Decoded measurement settings
  typedef struct packed {
    logic [5:0] cal_window_periods;
    logic [7:0] averaging_cycle_count;
    logic [2:0] stop_count;
  } tofcr_meas_cfg_s;

  // Turns the second configuration byte into engine settings
  function automatic tofcr_meas_cfg_s tofcr_decode(input logic [7:0] cfg);
    tofcr_meas_cfg_s d;
    d = '0;
    unique case (cfg[7:6])
      2'b00: d.cal_window_periods = 6'h02;
      2'b01: d.cal_window_periods = 6'h0a;
      2'b10: d.cal_window_periods = 6'h14;
      2'b11: d.cal_window_periods = 6'h28;
    endcase
    d.averaging_cycle_count = 8'h01 << cfg[5:3];
    d.stop_count = (cfg[2:0] <= 3'h4) ? cfg[2:0] + 3'h1 : 3'h1;
    return d;
  endfunction
endpackage

// [hdl/tofcr_regs.sv]
// Configuration, status and mask registers of one converter channel behind a serial port
`timescale 1ns/10ps

// Summary of operation
// - Config bits 7:6 pick a second calibration span of 2, 10, 20 or 40 periods, reset 01.
// - Config bits 5:3 ask for 2 to the code averaging cycles, 1 to 128, reset 000.
// - Config bits 2:0 ask for one to five stops, and codes above 100 mean one stop.
// - Status bit 4 sets on measurement done, like bit 0, and clears by writing one to it or to the begin bit.
// - Status bit 3 sets when the start event arrives and clears by writing one.
// - A reference counter overflow sets status bit 2 and halts the measurement at once.
// - A coarse counter overflow sets status bit 1 and halts the measurement at once.
// - Status bit 0 sets when a new result is ready and clears by writing one to it or to the begin bit.
// - Mask bit 2 enables the reference overflow interrupt and resets to one.
// - Mask bit 1 enables the coarse overflow interrupt and resets to one.
// - Mask bit 0 enables the result ready interrupt and resets to one.
// - A masked source stays off the interrupt pin but its status flag still sets.
// - Status bits 7:5 and mask bits 7:3 are reserved and stay zero.
// - Writing one to the begin bit clears all status flags and results and triggers, all in the same cycle.
module tofcr_regs
  import tofcr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic channel_select_n,
  input wire tofcr_events_s evt,
  output logic miso,
  output logic miso_oe,
  output logic irq_out_n,
  output logic meas_trigger,
  output logic meas_halt,
  output logic results_clear,
  output tofcr_meas_cfg_s meas_cfg,
  output logic [7:0] coarse_limit_high
);

  logic sclk_q1_ff, sclk_q2_ff, sclk_last_ff;
  logic mosi_q1_ff, mosi_q2_ff;
  logic csn_q1_ff, csn_q2_ff;
  logic sclk_rise, sclk_fall, sel;
  tofcr_spi_e state_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_in_ff, cmd_ff, shift_out_ff;
  logic wr_en_ff;
  logic [5:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic begin_ff;
  logic [7:0] cfg2_ff, status_ff, mask_ff;
  logic [7:0] nxt_status, nxt_mask, clr_vec, set_vec;
  logic start_wr;
  logic miso_ff, miso_oe_ff, irq_n_ff, trig_ff, halt_ff, rclr_ff;
  tofcr_meas_cfg_s meas_cfg_ff;
  logic [7:0] coarse_hi_ff;

  // Read data for an address; unmapped offsets read zero
  function automatic logic [7:0] rd_mux(input logic [5:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      ADDR_CONFIG_ONE: r = {7'h00, begin_ff};
      ADDR_CONFIG_TWO: r = cfg2_ff;
      ADDR_STATUS: r = status_ff & STATUS_USED;
      ADDR_MASK: r = mask_ff & MASK_USED;
      ADDR_COARSE_HI: r = coarse_hi_ff;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Two-stage synchronisers; serial pins are asynchronous to clk
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_q1_ff <= 1'b0;
      sclk_q2_ff <= 1'b0;
      sclk_last_ff <= 1'b0;
      mosi_q1_ff <= 1'b0;
      mosi_q2_ff <= 1'b0;
      csn_q1_ff <= 1'b1;
      csn_q2_ff <= 1'b1;
    end else begin
      sclk_q1_ff <= sclk;
      sclk_q2_ff <= sclk_q1_ff;
      sclk_last_ff <= sclk_q2_ff;
      mosi_q1_ff <= mosi;
      mosi_q2_ff <= mosi_q1_ff;
      csn_q1_ff <= channel_select_n;
      csn_q2_ff <= csn_q1_ff;
    end
  end

  // Edge detect on the synchronised serial clock only
  assign sclk_rise = sclk_q2_ff & ~sclk_last_ff;
  assign sclk_fall = ~sclk_q2_ff & sclk_last_ff;
  assign sel = ~csn_q2_ff;

  // Frame sequencer: command byte, then one data byte; extra bits are ignored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= SPI_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_in_ff <= 8'h00;
      cmd_ff <= 8'h00;
    end else if (!sel) begin
      state_ff <= SPI_IDLE;
      bit_cnt_ff <= 3'h0;
    end else begin
      unique case (state_ff)
        SPI_IDLE: state_ff <= SPI_CMD;
        SPI_CMD: begin
          if (sclk_rise) begin
            shift_in_ff <= {shift_in_ff[6:0], mosi_q2_ff};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == LAST_BIT) begin
              cmd_ff <= {shift_in_ff[6:0], mosi_q2_ff};
              state_ff <= SPI_DATA;
            end
          end
        end
        SPI_DATA: begin
          if (sclk_rise) begin
            shift_in_ff <= {shift_in_ff[6:0], mosi_q2_ff};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == LAST_BIT) begin
              state_ff <= SPI_TAIL;
            end
          end
        end
        SPI_TAIL: state_ff <= SPI_TAIL;
      endcase
    end
  end

  // Write strobe after the last data bit of a write frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_en_ff <= 1'b0;
      wr_addr_ff <= 6'h00;
      wr_data_ff <= 8'h00;
    end else begin
      wr_en_ff <= sel && state_ff == SPI_DATA && sclk_rise && bit_cnt_ff == LAST_BIT
        && cmd_ff[CMD_WRITE_BIT];
      if (sel && state_ff == SPI_DATA && sclk_rise && bit_cnt_ff == LAST_BIT) begin
        wr_addr_ff <= cmd_ff[5:0];
        wr_data_ff <= {shift_in_ff[6:0], mosi_q2_ff};
      end
    end
  end

  // Read path: load at end of command, shift out on falling edges, MSB first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_out_ff <= 8'h00;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= sel;
      if (!sel) begin
        miso_ff <= 1'b0;
      end else if (state_ff == SPI_CMD && sclk_rise && bit_cnt_ff == LAST_BIT) begin
        shift_out_ff <= rd_mux({shift_in_ff[4:0], mosi_q2_ff});
      end else if (state_ff == SPI_DATA && sclk_fall) begin
        miso_ff <= shift_out_ff[7];
        shift_out_ff <= {shift_out_ff[6:0], 1'b0};
      end
    end
  end

  // Begin request and status clearing terms
  assign start_wr = wr_en_ff && wr_addr_ff == ADDR_CONFIG_ONE
    && wr_data_ff[BEGIN_BIT];
  always_comb begin
    clr_vec = 8'h00;
    if (wr_en_ff && wr_addr_ff == ADDR_STATUS) begin
      clr_vec = wr_data_ff & STATUS_USED;
    end
    if (start_wr) begin
      clr_vec = STATUS_USED;
    end
    set_vec = 8'h00;
    set_vec[ST_DONE] = evt.done;
    set_vec[ST_STARTED] = evt.started;
    set_vec[ST_REF_OVF] = evt.ref_ovf;
    set_vec[ST_COARSE_OVF] = evt.coarse_ovf;
    set_vec[ST_RESULT] = evt.done;
    // Set wins over clear so no event is lost
    nxt_status = ((status_ff & ~clr_vec) | set_vec) & STATUS_USED;
    nxt_mask = mask_ff;
    if (wr_en_ff && wr_addr_ff == ADDR_MASK) begin
      nxt_mask = wr_data_ff & MASK_USED;
    end
  end

  // Status and mask registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_ff <= RST_STATUS;
      mask_ff <= RST_MASK;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
    end
  end

  // Plain configuration registers and the begin bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg2_ff <= RST_CONFIG_TWO;
      coarse_hi_ff <= RST_COARSE_HI;
      begin_ff <= 1'b0;
    end else begin
      if (wr_en_ff && wr_addr_ff == ADDR_CONFIG_TWO) begin
        cfg2_ff <= wr_data_ff;
      end
      if (wr_en_ff && wr_addr_ff == ADDR_COARSE_HI) begin
        coarse_hi_ff <= wr_data_ff;
      end
      // Begin bit drops when the run ends, normally or by overflow
      if (start_wr) begin
        begin_ff <= 1'b1;
      end else if (evt.done || evt.ref_ovf || evt.coarse_ovf) begin
        begin_ff <= 1'b0;
      end
    end
  end

  // Engine-facing outputs, all registered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_ff <= 1'b0;
      rclr_ff <= 1'b0;
      halt_ff <= 1'b0;
      meas_cfg_ff <= tofcr_decode(RST_CONFIG_TWO);
    end else begin
      trig_ff <= start_wr;
      rclr_ff <= start_wr;
      halt_ff <= evt.ref_ovf | evt.coarse_ovf;
      meas_cfg_ff <= tofcr_decode(cfg2_ff);
    end
  end

  // Interrupt pin from next state so it tracks the flags without lag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= ~|(nxt_status[2:0] & nxt_mask[2:0]);
    end
  end

  assign miso = miso_ff;
  assign miso_oe = miso_oe_ff;
  assign irq_out_n = irq_n_ff;
  assign meas_trigger = trig_ff;
  assign meas_halt = halt_ff;
  assign results_clear = rclr_ff;
  assign meas_cfg = meas_cfg_ff;
  assign coarse_limit_high = coarse_hi_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_cal_span: assert property (
    cfg2_ff[7:6] == 2'b11 |=> meas_cfg_ff.cal_window_periods == 6'h28)
    else $error("calibration span not 40");
  chk_avg_count: assert property (
    cfg2_ff[5:3] == 3'b111 |=> meas_cfg_ff.averaging_cycle_count == 8'h80)
    else $error("averaging count not 128");
  chk_stop_fallback: assert property (
    cfg2_ff[2:0] > 3'h4 |=> meas_cfg_ff.stop_count == 3'h1)
    else $error("stop code fallback wrong");
  chk_done_flags: assert property (
    evt.done |=> status_ff[ST_DONE] && status_ff[ST_RESULT])
    else $error("done flags not set");
  chk_started_flag: assert property (evt.started |=> status_ff[ST_STARTED])
    else $error("started flag not set");
  chk_ref_halt: assert property (evt.ref_ovf |=> status_ff[ST_REF_OVF] && meas_halt)
    else $error("reference overflow not flagged or halted");
  chk_coarse_halt: assert property (
    evt.coarse_ovf |=> status_ff[ST_COARSE_OVF] && meas_halt)
    else $error("coarse overflow not flagged or halted");
  chk_flag_sticky: assert property (
    status_ff[ST_RESULT] && !clr_vec[ST_RESULT] |=> status_ff[ST_RESULT])
    else $error("result flag dropped without clear");
  chk_irq_level: assert property (
    ##1 irq_out_n == !(|(status_ff[2:0] & mask_ff[2:0])))
    else $error("interrupt pin disagrees with flags");
  chk_reserved_zero: assert property (status_ff[7:5] == 3'h0 && mask_ff[7:3] == 5'h00)
    else $error("reserved bits set");
  chk_begin_clears: assert property (
    start_wr && !(|set_vec) |=> status_ff == 8'h00 && meas_trigger ##1 !meas_trigger)
    else $error("begin did not clear flags and trigger once");

endmodule

// [verif/tofcr_host.sv]
// Serial host model: mode 0 frames of one command byte and one data byte
`timescale 1ns/10ps
module tofcr_host (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic channel_select_n
);
  // Idle bus: deselected, clock low
  initial begin
    sclk = 1'b0;
    mosi = 1'b1;
    channel_select_n = 1'b1;
  end

  // Half period of 6 clk leaves margin over the 4 clk minimum of the synchroniser
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {1'b0, wr, a, wd};
    rd = 8'h00;
    @(posedge clk) channel_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      mosi <= sh[i];
      repeat (6) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8) rd[i] = miso; // Value settled before this edge
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
    end
    // Write lands about 4 clk after the last rise
    repeat (8) @(posedge clk);
    channel_select_n <= 1'b1;
    mosi <= ~mosi; // Stale data is never left on the line
    repeat (6) @(posedge clk);
  endtask
endmodule

// [verif/test_tofcr_regs.sv]
// Self-checking bench for the channel register slice
`timescale 1ns/10ps
module test_tofcr_regs import tofcr_pkg::*;;
  typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] r; logic [16:0] c;} tofcr_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, mosi, channel_select_n, miso, miso_oe, irq_out_n;
  logic meas_trigger, meas_halt, results_clear;
  logic [7:0] coarse_limit_high, bv;
  tofcr_events_s evt = '0;
  tofcr_meas_cfg_s meas_cfg;
  int mismatches = 0;
  int cmp_count = 0;
  int trig_cnt = 0;
  int clr_cnt = 0;
  int halt_cnt = 0;
  int oe_cnt = 0;
  int sel_cnt = 0;
  int irq_hi_cnt = 0;
  tofcr_row_s rows [11] = '{
    '{ADDR_CONFIG_TWO, 8'h00, 8'h00, {6'h02, 8'h01, 3'h1}},
    '{ADDR_CONFIG_TWO, 8'h94, 8'h94, {6'h14, 8'h04, 3'h5}},
    '{ADDR_CONFIG_TWO, 8'h6d, 8'h6d, {6'h0a, 8'h20, 3'h1}},
    '{ADDR_CONFIG_TWO, 8'hf3, 8'hf3, {6'h28, 8'h40, 3'h4}},
    '{ADDR_CONFIG_TWO, 8'h4a, 8'h4a, {6'h0a, 8'h02, 3'h3}},
    '{ADDR_CONFIG_TWO, 8'h9e, 8'h9e, {6'h14, 8'h08, 3'h1}},
    '{ADDR_CONFIG_TWO, 8'h21, 8'h21, {6'h02, 8'h10, 3'h2}},
    '{ADDR_CONFIG_TWO, 8'hff, 8'hff, {6'h28, 8'h80, 3'h1}},
    '{ADDR_MASK, 8'hff, 8'h07, 17'h0},
    '{ADDR_STATUS, 8'hff, 8'h00, 17'h0},
    '{ADDR_COARSE_HI, 8'h5a, 8'h5a, 17'h0}};

  tofcr_regs tofcr_regs_inst (.clk(clk), .nrst(nrst), .sclk(sclk), .mosi(mosi),
    .channel_select_n(channel_select_n), .evt(evt), .miso(miso), .miso_oe(miso_oe),
    .irq_out_n(irq_out_n), .meas_trigger(meas_trigger), .meas_halt(meas_halt),
    .results_clear(results_clear), .meas_cfg(meas_cfg), .coarse_limit_high(coarse_limit_high));
  tofcr_host tofcr_host_inst (.clk(clk), .miso(miso), .sclk(sclk), .mosi(mosi),
    .channel_select_n(channel_select_n));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Pulse counters, so a stuck or doubled strobe shows up
  always @(posedge clk) begin
    if (nrst && meas_trigger) trig_cnt++;
    if (nrst && results_clear) clr_cnt++;
    if (nrst && meas_halt) halt_cnt++;
    if (nrst && miso_oe) oe_cnt++;
    if (nrst && !channel_select_n) sel_cnt++;
    if (nrst && irq_out_n) irq_hi_cnt++;
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    tofcr_host_inst.xfer(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] x;
    tofcr_host_inst.xfer(1'b0, a, 8'h00, x);
    chk({9'h000, x}, {9'h000, e});
  endtask

  // One-cycle event strobe, then time for flag and halt to settle
  task automatic fire(input logic [3:0] e);
    @(posedge clk) evt <= tofcr_events_s'(e);
    @(posedge clk) evt <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk) nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    do_reset();
    oe_cnt = 0;
    sel_cnt = 0;
    rdchk(ADDR_CONFIG_TWO, 8'h40);
    // Output enable spans as many cycles as the select, only later
    chk(17'(oe_cnt), 17'(sel_cnt));
    chk({16'h0000, miso_oe}, 17'h0);
    rdchk(ADDR_STATUS, 8'h00);
    rdchk(ADDR_MASK, 8'h07);
    rdchk(ADDR_COARSE_HI, 8'hff);
    chk(meas_cfg, {6'h0a, 8'h01, 3'h1});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
      if (rows[i].a == ADDR_CONFIG_TWO) chk(meas_cfg, rows[i].c);
    end
    chk({9'h000, coarse_limit_high}, 17'h0005a);
    // Unmapped write must disturb nothing
    wr(6'h3f, 8'h00);
    rdchk(ADDR_MASK, 8'h07);
    // Completion with its source masked, then unmasked
    wr(ADDR_MASK, 8'h06);
    fire(4'b1000);
    chk({16'h0000, irq_out_n}, 17'h1);
    rdchk(ADDR_STATUS, 8'h11);
    wr(ADDR_MASK, 8'h07);
    chk({16'h0000, irq_out_n}, 17'h0);
    wr(ADDR_STATUS, 8'h00);
    rdchk(ADDR_STATUS, 8'h11);
    wr(ADDR_STATUS, 8'h01);
    rdchk(ADDR_STATUS, 8'h10);
    chk({16'h0000, irq_out_n}, 17'h1);
    wr(ADDR_STATUS, 8'h10);
    fire(4'b0100);
    rdchk(ADDR_STATUS, 8'h08);
    chk({16'h0000, irq_out_n}, 17'h1);
    // Both overflows: halt, pin, masking, clearing
    for (int j = 0; j < 2; j++) begin
      bv = 8'h04 >> j;
      halt_cnt = 0;
      fire(4'b0010 >> j);
      chk(17'(halt_cnt), 17'h1);
      chk({16'h0000, irq_out_n}, 17'h0);
      wr(ADDR_MASK, ~bv & 8'h07);
      chk({16'h0000, irq_out_n}, 17'h1);
      rdchk(ADDR_STATUS, bv | 8'h08);
      wr(ADDR_STATUS, bv);
      wr(ADDR_MASK, 8'h07);
      rdchk(ADDR_STATUS, 8'h08);
    end
    // Completion held through a clearing write: pin must never rise
    @(posedge clk) evt <= tofcr_events_s'(4'b1000);
    repeat (2) @(posedge clk);
    irq_hi_cnt = 0;
    wr(ADDR_STATUS, 8'h11);
    chk(17'(irq_hi_cnt), 17'h0);
    @(posedge clk) evt <= '0;
    rdchk(ADDR_STATUS, 8'h19);
    // Begin bit clears every flag and pulses trigger and clear once
    trig_cnt = 0;
    clr_cnt = 0;
    wr(ADDR_CONFIG_ONE, 8'h01);
    rdchk(ADDR_STATUS, 8'h00);
    chk(17'(trig_cnt), 17'h1);
    chk(17'(clr_cnt), 17'h1);
    rdchk(ADDR_CONFIG_ONE, 8'h01);
    fire(4'b1000);
    rdchk(ADDR_CONFIG_ONE, 8'h00);
    // Reset after the run has ended restores the defaults
    do_reset();
    rdchk(ADDR_CONFIG_TWO, 8'h40);
    rdchk(ADDR_STATUS, 8'h00);
    chk({16'h0000, irq_out_n}, 17'h1);
    chk({16'h0000, miso_oe}, 17'h0);
    report_and_stop();
  end
endmodule
